// ==== hdl/cpseq_params.svh ====
// Constants for the charger power-up sequencer: offsets, fields, resets, timing.
// Assumes a 40 MHz system clock; included by the design, the checker and the bench.
`ifndef CPSEQ_PARAMS_SVH
`define CPSEQ_PARAMS_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define CPSEQ_OFS_INPUT     8'h00
`define CPSEQ_OFS_POWERON   8'h04
`define CPSEQ_OFS_TIMER     8'h14
`define CPSEQ_OFS_MISC      8'h1C
`define CPSEQ_OFS_STATUS    8'h20
`define CPSEQ_OFS_ANALOG    8'h40

// ==========================================================================
// Field positions
`define CPSEQ_HIZ_BIT       7
`define CPSEQ_REGRST_BIT    7
`define CPSEQ_WDT_LSB       4
`define CPSEQ_SWOFF_BIT     5
`define CPSEQ_DETECT_BIT    7
`define CPSEQ_PG_BIT        2
`define CPSEQ_SRC_LSB       6

// ==========================================================================
// Reset values
`define CPSEQ_ILIM_RST      3'h2
`define CPSEQ_WDT_RST       2'h1

// ==========================================================================
// Input current limit codes
`define CPSEQ_ILIM_100MA    3'h0
`define CPSEQ_ILIM_500MA    3'h2
`define CPSEQ_ILIM_3A       3'h7

// Source type codes
`define CPSEQ_SRC_UNKNOWN   2'h0
`define CPSEQ_SRC_HOST      2'h1
`define CPSEQ_SRC_ADAPTER   2'h2

// ==========================================================================
// Timing
`define CPSEQ_CLK_HZ        40000000
`define CPSEQ_REG_DELAY_MS  100
`define CPSEQ_RETRY_MS      2000
`define CPSEQ_WAKE_MS       2
`define CPSEQ_WDT_UNIT_S    40
`define CPSEQ_REG_DELAY_CYC ((`CPSEQ_CLK_HZ / 1000) * `CPSEQ_REG_DELAY_MS)
`define CPSEQ_RETRY_CYC     ((`CPSEQ_CLK_HZ / 1000) * `CPSEQ_RETRY_MS)
`define CPSEQ_WAKE_CYC      ((`CPSEQ_CLK_HZ / 1000) * `CPSEQ_WAKE_MS)
`define CPSEQ_WDT_UNIT_CYC  (`CPSEQ_CLK_HZ * `CPSEQ_WDT_UNIT_S)

`endif

// ==== hdl/cpseq_pkg.sv ====
// Types for the charger power-up sequencer.
// Constants live in cpseq_params.svh.
package cpseq_pkg;

	// ======================================================================
	// Analog comparator levels, already synchronised or raw from pins
	typedef struct packed {
		logic input_above_uvlo;  // Input above undervoltage release
		logic battery_above_uvlo;// Battery above undervoltage release
		logic battery_above_depl;// Battery above depletion threshold
		logic input_above_sleep; // Input above battery plus sleep margin
		logic input_overvoltage; // Input above overvoltage threshold
		logic input_above_poor;  // Input above poor-source threshold under load
		logic discharge_overload;// Battery discharge overload or short
		logic boost_mode;        // Converter is in boost mode
	} cpseq_analog_t;

	// Sequencer states
	typedef enum logic [2:0] {
		CPSEQ_HIZ,
		CPSEQ_REG_WAIT,
		CPSEQ_QUALIFY,
		CPSEQ_RETRY_WAIT,
		CPSEQ_DETECT,
		CPSEQ_RUN
	} cpseq_state_t;

endpackage

// ==== hdl/cpseq_top.sv ====
// Power-up sequencer for a single-cell charger with an Avalon-MM slave.
// Assumes comparator levels and pins arrive asynchronously; one 40 MHz clock.
//
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "cpseq_params.svh"

// How it works
// - Supply rise resets registers, stalls bus
// - Battery only: switch closed, regulator off
// - Overload opens switch until input returns
// - Switch-off bit forces battery switch open
// - Five events close switch, clear bit
// - Regulator on after three conditions, delay
// - Any failed condition: high impedance, regulator off
// - Buck starts only without overvoltage, good source
// - Qualified source sets power-good, pin, interrupt
// - Poor source retried every two seconds
// - Detection runs after qualification or on request, never in high impedance
// - Limit from port select and OTG pins
// - Detection writes source type and limit
// - Host may overwrite limit field except in the detection cycle
// - Host port limited; charging port three amps
// - Host high impedance held until cleared
module cpseq_top (
	input  wire logic                  clk_sys_in,          // 40 MHz system clock
	input  wire logic                  rst_in,              // Synchronous reset, high
	input  wire logic [7:0]            avs_address_in,      // Byte address
	input  wire logic                  avs_read_in,         // Read strobe
	input  wire logic                  avs_write_in,        // Write strobe
	input  wire logic [31:0]           avs_writedata_in,    // Write data
	input  wire logic [3:0]            avs_byteenable_in,   // Byte enables
	output logic      [31:0]           avs_readdata_out,    // Read data
	output logic                       avs_waitrequest_out, // Wait request
	input  wire cpseq_pkg::cpseq_analog_t analog_in,        // Comparator levels
	input  wire logic                  wake_pin_in,         // Wake pin
	input  wire logic                  port_select_in,      // Port select pin
	input  wire logic                  otg_pin_in,          // OTG pin
	output logic                       battery_switch_out,  // Battery switch closed
	output logic                       internal_regulator_out, // Regulator enable
	output logic                       buck_enable_out,     // Buck converter enable
	output logic                       power_good_n_out,    // Power-good pin, low active
	output logic                       int_out              // Host interrupt pulse
);
	import cpseq_pkg::*;

	// ======================================================================
	// Input synchronisers: two flops on every asynchronous level
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] sync1_q;     // First stage, read only by second
	logic [NSYNC-1:0] sync2_q;     // Usable stage
	always_ff @(posedge clk_sys_in) begin
		sync1_q <= {analog_in, wake_pin_in, port_select_in, otg_pin_in};
		sync2_q <= sync1_q;
	end

	cpseq_analog_t an;             // Synchronised comparator levels
	logic          wake_s;         // Synchronised wake pin
	logic          psel_s;         // Synchronised port select
	logic          otg_s;          // Synchronised OTG pin
	assign an     = sync2_q[10:3];
	assign wake_s = sync2_q[2];
	assign psel_s = sync2_q[1];
	assign otg_s  = sync2_q[0];

	// ======================================================================
	// Supply release tracking: a rise of either supply is a power-on reset
	logic battery_q;               // Previous battery level
	logic input_q;                 // Previous input level
	logic por_pulse;               // A supply just came up
	logic input_attach;            // Input source just attached
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			battery_q <= 1'b0;
			input_q   <= 1'b0;
		end else begin
			battery_q <= an.battery_above_uvlo;
			input_q   <= an.input_above_uvlo;
		end
	end
	assign input_attach = an.input_above_uvlo & ~input_q;
	// Each supply's own rise counts, so an adapter plugged onto a live battery resets too
	assign por_pulse    = input_attach | (an.battery_above_uvlo & ~battery_q);

	// ======================================================================
	// Bus decode
	logic wr_en;                   // Write accepted this cycle
	logic rd_en;                   // Read accepted this cycle
	logic wr_b0;                   // Low byte written
	logic soft_reset;              // Register reset bit written one
	logic reg_clear;               // Any register reset
	logic wdt_expire;              // Watchdog timed out
	logic rd_ack_q;                // Read data loaded, read is answered now
	// Stall while registers return to defaults, and for one cycle on every read:
	// read data come from a flop, yet must stand at the edge that takes the read
	assign avs_waitrequest_out = por_pulse | (avs_read_in & ~rd_ack_q);
	assign wr_en = avs_write_in & ~avs_waitrequest_out;
	assign rd_en = avs_read_in & ~avs_waitrequest_out;
	assign wr_b0 = wr_en & avs_byteenable_in[0];
	assign soft_reset = wr_b0 && avs_address_in == `CPSEQ_OFS_POWERON
		&& avs_writedata_in[`CPSEQ_REGRST_BIT];
	assign reg_clear = rst_in | por_pulse | soft_reset;

	// ======================================================================
	// Registers
	logic       hiz_q;             // Host high-impedance control
	logic [2:0] ilim_q;            // Input current limit field
	logic [1:0] wdt_q;             // Watchdog setting, 00 is off
	logic       sw_off_q;          // Battery switch off bit
	logic       detect_req_q;      // Forced detection request
	logic [1:0] src_q;             // Source type status
	logic       pg_q;              // Power-good status
	logic       overload_q;        // Switch latched open by overload
	logic       det_done;          // Detection finished this cycle
	logic [2:0] det_ilim;          // Detected limit
	logic [1:0] det_src;           // Detected source type
	logic       wake_event;        // Wake pin held long enough
	cpseq_state_t state_q;         // Sequencer state

	// Host high-impedance bit holds until software writes zero
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear) begin
			hiz_q <= 1'b0;
		end else if (wr_b0 && avs_address_in == `CPSEQ_OFS_INPUT) begin
			hiz_q <= avs_writedata_in[`CPSEQ_HIZ_BIT];
		end
	end

	// Limit field: host writes and detection results, else unchanged
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear) begin
			ilim_q <= `CPSEQ_ILIM_RST;
			src_q  <= `CPSEQ_SRC_UNKNOWN;
		end else if (det_done) begin
			// Detection wins over a same-cycle host write: it is the newer fact
			ilim_q <= det_ilim;
			src_q  <= det_src;
		end else if (wr_b0 && avs_address_in == `CPSEQ_OFS_INPUT) begin
			ilim_q <= avs_writedata_in[2:0];
		end
	end

	// Watchdog setting
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear) begin
			wdt_q <= `CPSEQ_WDT_RST;
		end else if (wr_b0 && avs_address_in == `CPSEQ_OFS_TIMER) begin
			wdt_q <= avs_writedata_in[`CPSEQ_WDT_LSB +: 2];
		end
	end

	// Switch-off bit and forced detection; wake events clear the bit
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear) begin
			sw_off_q     <= 1'b0;
			detect_req_q <= 1'b0;
		end else begin
			// Clear first, so a request raised in the finishing cycle survives
			if (det_done) begin
				detect_req_q <= 1'b0;
			end
			if (wr_b0 && avs_address_in == `CPSEQ_OFS_MISC) begin
				sw_off_q <= avs_writedata_in[`CPSEQ_SWOFF_BIT];
				if (avs_writedata_in[`CPSEQ_DETECT_BIT]) begin
					detect_req_q <= 1'b1;
				end
			end
			if (input_attach || wdt_expire || wake_event) begin
				sw_off_q <= 1'b0;
			end
			if (wdt_expire) begin
				detect_req_q <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Watchdog: any bus access kicks it; off when setting is 00
	logic [32:0] wdt_cnt_q;        // Cycles since last kick
	logic [32:0] wdt_limit;        // Timeout in cycles; three units overflow 32 bits
	always_comb begin
		wdt_limit = 33'(`CPSEQ_WDT_UNIT_CYC) * 33'(wdt_q);
	end
	// Restarts after each expiry so that one timeout is one event
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear || wr_en || rd_en || wdt_q == 2'h0 || wdt_expire) begin
			wdt_cnt_q <= 33'h0;
		end else begin
			wdt_cnt_q <= wdt_cnt_q + 33'h1;
		end
	end
	assign wdt_expire = wdt_q != 2'h0 && wdt_cnt_q >= wdt_limit - 33'h1;

	// ======================================================================
	// Wake pin: rising edge, then held high for the minimum time
	logic        wake_prev_q;      // Previous wake level
	logic        wake_arm_q;       // Edge seen, timing high time
	logic [19:0] wake_cnt_q;       // High-time counter
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wake_prev_q <= 1'b0;
			wake_arm_q  <= 1'b0;
			wake_cnt_q  <= 20'h0;
		end else begin
			wake_prev_q <= wake_s;
			if (!wake_s) begin
				wake_arm_q <= 1'b0;
				wake_cnt_q <= 20'h0;
			end else if (!wake_prev_q) begin
				wake_arm_q <= 1'b1;
				wake_cnt_q <= 20'h0;
			end else if (wake_arm_q) begin
				wake_cnt_q <= wake_cnt_q + 20'h1;
				if (wake_event) begin
					wake_arm_q <= 1'b0;
				end
			end
		end
	end
	// Counter lags the first high sample by one: N-2 marks N samples high
	assign wake_event = wake_arm_q && wake_cnt_q == 20'(`CPSEQ_WAKE_CYC - 2);

	// ======================================================================
	// Overload latch: opens the switch until the input attaches again
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			overload_q <= 1'b0;
		end else if (an.discharge_overload) begin
			overload_q <= 1'b1;
		end else if (input_attach) begin
			overload_q <= 1'b0;
		end
	end

	// Switch closed when battery usable and nothing forces it open
	assign battery_switch_out = an.battery_above_depl & ~sw_off_q & ~overload_q
		& ~an.discharge_overload;

	// ======================================================================
	// Sequencer
	logic        reg_ok;           // Regulator conditions met apart from delay
	logic [27:0] tmr_q;            // Shared delay counter
	assign reg_ok = an.input_above_uvlo
		& (an.boost_mode ? ~an.input_above_sleep : an.input_above_sleep);

	always_ff @(posedge clk_sys_in) begin
		if (rst_in || !reg_ok || hiz_q) begin
			state_q <= CPSEQ_HIZ;
			tmr_q   <= 28'h0;
		end else begin
			case (state_q)
				CPSEQ_HIZ: begin
					state_q <= CPSEQ_REG_WAIT;
					tmr_q   <= 28'h0;
				end
				CPSEQ_REG_WAIT: begin
					// Waits the minimum delay before the regulator may start
					if (tmr_q == 28'(`CPSEQ_REG_DELAY_CYC - 1)) begin
						state_q <= CPSEQ_QUALIFY;
					end else begin
						tmr_q <= tmr_q + 28'h1;
					end
				end
				CPSEQ_QUALIFY: begin
					tmr_q <= 28'h0;
					if (!an.input_overvoltage && an.input_above_poor) begin
						state_q <= CPSEQ_DETECT;
					end else begin
						state_q <= CPSEQ_RETRY_WAIT;
					end
				end
				CPSEQ_RETRY_WAIT: begin
					if (tmr_q == 28'(`CPSEQ_RETRY_CYC - 1)) begin
						state_q <= CPSEQ_QUALIFY;
					end else begin
						tmr_q <= tmr_q + 28'h1;
					end
				end
				CPSEQ_DETECT: begin
					state_q <= CPSEQ_RUN;
				end
				CPSEQ_RUN: begin
					if (detect_req_q) begin
						state_q <= CPSEQ_DETECT;
					end
				end
				default: begin
					state_q <= CPSEQ_HIZ;
				end
			endcase
		end
	end

	// Detection from the port select and OTG pins
	assign det_done = state_q == CPSEQ_DETECT;
	always_comb begin
		if (!psel_s) begin
			det_ilim = `CPSEQ_ILIM_3A;
			det_src  = `CPSEQ_SRC_ADAPTER;
		end else begin
			det_ilim = otg_s ? `CPSEQ_ILIM_500MA : `CPSEQ_ILIM_100MA;
			det_src  = `CPSEQ_SRC_HOST;
		end
	end

	// Power-good status and a one-cycle interrupt on qualification
	logic pg_set;                  // Source passed qualification now
	assign pg_set = state_q == CPSEQ_QUALIFY && reg_ok && !hiz_q && !rst_in
		&& !an.input_overvoltage && an.input_above_poor;
	always_ff @(posedge clk_sys_in) begin
		if (reg_clear || !an.input_above_uvlo) begin
			pg_q  <= 1'b0;
			int_out <= 1'b0;
		end else begin
			int_out <= pg_set & ~pg_q;
			if (pg_set) begin
				pg_q <= 1'b1;
			end
		end
	end

	assign power_good_n_out       = ~pg_q;
	assign internal_regulator_out = state_q != CPSEQ_HIZ && state_q != CPSEQ_REG_WAIT;
	assign buck_enable_out        = state_q == CPSEQ_RUN || state_q == CPSEQ_DETECT;

	// ======================================================================
	// Read answer flag: set by the loading cycle, cleared when the read is taken
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_ack_q <= 1'b0;
		end else begin
			rd_ack_q <= avs_read_in & ~rd_en;
		end
	end

	// Read data, registered in the stall cycle; unmapped offsets read zero
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			avs_readdata_out <= 32'h0;
		end else if (avs_read_in && !rd_ack_q) begin
			if (avs_address_in == `CPSEQ_OFS_INPUT) begin
				avs_readdata_out <= {24'h0, hiz_q, 4'h0, ilim_q};
			end else if (avs_address_in == `CPSEQ_OFS_TIMER) begin
				avs_readdata_out <= {26'h0, wdt_q, 4'h0};
			end else if (avs_address_in == `CPSEQ_OFS_MISC) begin
				avs_readdata_out <= {24'h0, detect_req_q, 1'b0, sw_off_q, 5'h0};
			end else if (avs_address_in == `CPSEQ_OFS_STATUS) begin
				avs_readdata_out <= {24'h0, src_q, 3'h0, pg_q, 2'h0};
			end else if (avs_address_in == `CPSEQ_OFS_ANALOG) begin
				avs_readdata_out <= {21'h0, state_q, an};
			end else begin
				avs_readdata_out <= 32'h0;
			end
		end
	end
endmodule

// ==== verification/cpseq_top_props.sv ====
// Port checker for the power-up sequencer, bound into the top module.
// Assumes only the top ports; inputs pass a 2-flop synchroniser.
`timescale 1ns/1ps
`include "cpseq_params.svh"
// ==========================================================================
// Checker
module cpseq_top_props (
	input wire logic                     clk_sys_in,
	input wire logic                     rst_in,
	input wire logic [7:0]               avs_address_in,
	input wire logic                     avs_write_in,
	input wire logic [31:0]              avs_writedata_in,
	input wire logic [3:0]               avs_byteenable_in,
	input wire logic                     avs_read_in,
	input wire logic [31:0]              avs_readdata_out,
	input wire logic                     avs_waitrequest_out,
	input wire cpseq_pkg::cpseq_analog_t analog_in,
	input wire logic                     battery_switch_out,
	input wire logic                     internal_regulator_out,
	input wire logic                     buck_enable_out,
	input wire logic                     power_good_n_out,
	input wire logic                     int_out
);
	import cpseq_pkg::*;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	// Accepted lane-0 writes and reads
	sequence s_wr(a);
		avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] && avs_address_in == a;
	endsequence
	sequence s_rd(a);
		avs_read_in && !avs_waitrequest_out && avs_address_in == a;
	endsequence
	// Host limit write, gap, readback of the same field
	AST_ILIM_READBACK: assert property (s_wr(`CPSEQ_OFS_INPUT) ##3 s_rd(`CPSEQ_OFS_INPUT)
		|-> avs_readdata_out[2:0] == $past(avs_writedata_in[2:0], 3)) else $error("ilim");
	AST_SWOFF_OPENS: assert property (s_wr(`CPSEQ_OFS_MISC) ##0 avs_writedata_in[5]
		|=> !battery_switch_out [*3]) else $error("switch not opened");
	AST_OVERLOAD_OPENS: assert property (analog_in.discharge_overload [*6]
		|-> !battery_switch_out) else $error("switch closed in overload");
	AST_REG_OFF_NO_INPUT: assert property (!analog_in.input_above_uvlo [*6]
		|-> !internal_regulator_out) else $error("regulator on without input");
	AST_BUCK_OFF_NO_INPUT: assert property (!analog_in.input_above_uvlo [*6]
		|-> !buck_enable_out) else $error("buck on without input");
	AST_BUCK_NEEDS_REG: assert property (buck_enable_out |-> internal_regulator_out)
		else $error("buck without regulator");
	AST_INT_PULSE: assert property (int_out |=> !int_out) else $error("int too long");
	AST_INT_WITH_PG: assert property (int_out |-> ##[0:2] !power_good_n_out)
		else $error("int without power good");
	AST_POR_STALL: assert property ($rose(analog_in.input_above_uvlo)
		|-> ##[1:5] avs_waitrequest_out) else $error("no stall on supply rise");
	AST_STALL_ONE: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("stall longer than one cycle");
endmodule
bind cpseq_top cpseq_top_props cpseq_top_props_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
	.avs_address_in(avs_address_in), .avs_write_in(avs_write_in), .avs_read_in(avs_read_in),
	.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.analog_in(analog_in), .battery_switch_out(battery_switch_out),
	.internal_regulator_out(internal_regulator_out), .buck_enable_out(buck_enable_out),
	.power_good_n_out(power_good_n_out), .int_out(int_out));

// ==== verification/cpseq_top_test.sv ====
// Self-checking bench for the power-up sequencer over Avalon-MM.
// Assumes a 40 MHz clock; the regulator delay is too long to reach here.
`timescale 1ns/1ps
`include "cpseq_params.svh"
module cpseq_top_test;
	import cpseq_pkg::*;
	logic clk_sys_in, rst_in, link_clk, wake_req, wake_pin;
	logic [7:0] adr;
	logic rd, wr, wreq, sw, rg, bk, pgn, irq;
	logic [31:0] wd, rdat, q;
	cpseq_analog_t ana;
	logic [2:0] lims [3] = '{3'h0, 3'h2, 3'h7}; // Limit codes written and read back
	int num_errors = 0;
	int n_checks = 0;
	cpseq_top cpseq_top_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .analog_in(ana),
		.wake_pin_in(wake_pin), .port_select_in(1'b1), .otg_pin_in(1'b1),
		.battery_switch_out(sw), .internal_regulator_out(rg), .buck_enable_out(bk),
		.power_good_n_out(pgn), .int_out(irq));
	cpseq_wake_model #(.HOLD_CYC(10000)) cpseq_wake_model_inst (.link_clk_in(link_clk),
		.start_in(wake_req), .wake_pin_out(wake_pin));
	// ======================================================================
	// Clocks, 25 ns system and an unrelated 200 ns link
	initial begin
		clk_sys_in = 0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	initial begin
		link_clk = 0;
		#37;
		forever #100 link_clk = ~link_clk;
	end
	// ======================================================================
	// Checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// One bus cycle; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			num_errors++;
			conclude();
		end
		// Read data stand at the very edge that takes the read
		if (!w) begin
			q = rdat;
		end
		wr <= 0;
		rd <= 0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(0, a, 0);
		chk(q, exp);
	endtask
	// Bounded wait for the switch to reach a level
	task automatic wait_sw(input logic exp, input int lim);
		int n;
		n = 0;
		while (sw !== exp && n < lim) begin
			@(posedge clk_sys_in);
			n++;
		end
		chk(sw, exp);
	endtask
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		num_errors++;
		conclude();
	end
	// ======================================================================
	// Test sequence
	initial begin
		{rst_in, rd, wr, adr, wd, wake_req} = {1'b1, 43'h0};
		ana = '0;
		ana.battery_above_uvlo = 1;
		ana.battery_above_depl = 1;
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 0;
		repeat (8) @(posedge clk_sys_in);
		rdc(`CPSEQ_OFS_INPUT, 32'h02);
		rdc(`CPSEQ_OFS_TIMER, 32'h10);
		rdc(`CPSEQ_OFS_MISC, 32'h00);
		rdc(8'h30, 32'h00);
		rdc(`CPSEQ_OFS_STATUS, 32'h00);
		chk({sw, rg, bk, pgn}, 4'h9);
		$display("test reset and battery start done");
		bus(1, `CPSEQ_OFS_INPUT, 32'h82);
		rdc(`CPSEQ_OFS_INPUT, 32'h82);
		foreach (lims[i]) begin
			bus(1, `CPSEQ_OFS_INPUT, {29'h0, lims[i]});
			rdc(`CPSEQ_OFS_INPUT, {29'h0, lims[i]});
		end
		$display("test limit field done");
		bus(1, `CPSEQ_OFS_MISC, 32'h20);
		wait_sw(0, 10);
		rdc(`CPSEQ_OFS_MISC, 32'h20);
		bus(1, `CPSEQ_OFS_MISC, 32'h00);
		wait_sw(1, 10);
		$display("test switch-off bit done");
		bus(1, `CPSEQ_OFS_TIMER, 32'h00);
		bus(1, `CPSEQ_OFS_MISC, 32'h20);
		rdc(`CPSEQ_OFS_TIMER, 32'h00);
		bus(1, `CPSEQ_OFS_POWERON, 32'h80);
		wait_sw(1, 10);
		rdc(`CPSEQ_OFS_MISC, 32'h00);
		rdc(`CPSEQ_OFS_TIMER, 32'h10);
		$display("test shipping and register reset done");
		bus(1, `CPSEQ_OFS_MISC, 32'h20);
		wake_req <= 1;
		repeat (2000) @(posedge clk_sys_in);
		wake_req <= 0;
		chk(sw, 0);
		wait_sw(1, 90000);
		rdc(`CPSEQ_OFS_MISC, 32'h00);
		$display("test wake pin done");
		bus(1, `CPSEQ_OFS_INPUT, 32'h07);
		ana.discharge_overload <= 1;
		wait_sw(0, 10);
		ana.discharge_overload <= 0;
		repeat (10) @(posedge clk_sys_in);
		chk(sw, 0);
		ana.input_above_uvlo <= 1;
		wait_sw(1, 20);
		rdc(`CPSEQ_OFS_INPUT, 32'h02);
		repeat (100) @(posedge clk_sys_in);
		chk({rg, bk}, 2'h0);
		chk(irq, 1'b0);
		$display("test overload and input attach done");
		conclude();
	end
endmodule

// ==== verification/cpseq_wake_model.sv ====
// Far-side pin model: drives the wake pin from a free link clock.
// Assumes the bench supplies the 200 ns link clock and a start request.
`timescale 1ns/1ps
// ==========================================================================
// Wake pin driver
module cpseq_wake_model #(
	parameter int HOLD_CYC = 10000 // Link cycles held high (2 ms at 200 ns)
) (
	input  wire logic link_clk_in,  // Free-running link clock
	input  wire logic start_in,     // Level request to begin a wake press
	output logic      wake_pin_out  // Wake pin, pulled low when idle
);
	int cnt_q = 0; // Remaining high cycles

	// Holds the pin high for the full press, then lets the pull-down win
	always_ff @(posedge link_clk_in) begin
		if (start_in && cnt_q == 0) begin
			cnt_q <= HOLD_CYC;
		end else if (cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
	assign wake_pin_out = (cnt_q > 0);
endmodule
